// [hw/fcd_regs.svh]
// timing counts, command codes and addresses for the flash command host
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH
`define FCD_ADDR_W 19
`define FCD_UNLOCK1_ADDR 19'h05555
`define FCD_UNLOCK2_ADDR 19'h02aaa
`define FCD_UNLOCK1_DATA 8'haa
`define FCD_UNLOCK2_DATA 8'h55
`define FCD_CMD_RESET 8'hf0
`define FCD_CMD_IDENT 8'h90
`define FCD_CMD_PROGRAM 8'ha0
`define FCD_CMD_ERASE_SETUP 8'h80
`define FCD_CMD_CHIP_ERASE 8'h10
`define FCD_CMD_SECTOR_ERASE 8'h30
`define FCD_CMD_SUSPEND 8'hb0
`define FCD_CMD_RESUME 8'h30
`define FCD_ID_MAKER_ADDR 19'h00000
`define FCD_ID_PART_ADDR 19'h00001
`define FCD_PROTECT_LOW 19'h00002
`define FCD_POLL_BIT 7
`define FCD_LIMIT_BIT 5
`define FCD_PROTECT_BIT 0
`define FCD_STROBE_NS 200
`define FCD_CLK_NS 100
`define FCD_STROBE_CYC ((`FCD_STROBE_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// [hw/fcd_pkg.sv]
// types for the flash command host
package fcd_pkg;
   typedef enum logic [2:0] {
      fcd_op_reset,
      fcd_op_reset_long,
      fcd_op_ident_read,
      fcd_op_program,
      fcd_op_chip_erase,
      fcd_op_sector_erase,
      fcd_op_suspend,
      fcd_op_resume
   } fcd_op_type;
endpackage

// [hw/fcd_bus_cycle.sv]
// one write or read bus cycle on the flash pins
`timescale 1ns/100ps
`include "fcd_regs.svh"
module fcd_bus_cycle
   import fcd_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire logic is_write,
   input wire logic [18:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] dq_in,
   output logic [18:0] flash_addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   output logic chip_sel_n,
   output logic write_n,
   output logic out_en_n,
   output logic [7:0] rdata,
   output logic done
);
   localparam int unsigned STROBE = `FCD_STROBE_CYC;
   logic [3:0] count;
   logic busy;
   logic wr;

   // address set up before strobes fall; data held past the rise
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         busy <= 1'b0;
         count <= 4'h0;
         wr <= 1'b0;
         flash_addr <= 19'h00000;
         dq_out <= 8'h00;
         dq_oe <= 1'b0;
         chip_sel_n <= 1'b1;
         write_n <= 1'b1;
         out_en_n <= 1'b1;
         rdata <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            count <= 4'h0;
            wr <= is_write;
            flash_addr <= addr;
            dq_out <= wdata;
            dq_oe <= is_write;
         end else if (busy) begin
            count <= count + 4'h1;
            if (count == 4'h0) begin
               chip_sel_n <= 1'b0;
               write_n <= ~wr;
               out_en_n <= wr;
            end else if (count == 4'(STROBE)) begin
               // chip select and strobe rise together: data latch and start
               chip_sel_n <= 1'b1;
               write_n <= 1'b1;
               out_en_n <= 1'b1;
               if (!wr) begin
                  rdata <= dq_in;
               end
            end else if (count == 4'(STROBE + 1)) begin
               dq_oe <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   AST_WRITE_NOT_READ: assert property (@(posedge mclk) disable iff (reset)
      !(~write_n && ~out_en_n))
      else $error("write strobe and output enable low together");
   AST_STROBE_WIDTH: assert property (@(posedge mclk) disable iff (reset)
      $fell(chip_sel_n) |-> !chip_sel_n [*2] ##1 chip_sel_n) // R12
      else $error("chip select pulse width wrong");
   AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (reset)
      !chip_sel_n |-> $stable(flash_addr)) // R12
      else $error("address moved while selected");
endmodule

// [hw/fcd_host.sv]
// host controller driving flash command sequences
//
// Behaviour
// R1 - bad or misordered cycle resets device
// R2 - suspend and resume only during sector erase; host also records suspend after chip erase
// R3 - reset by F0H or unlock sequence
// R4 - multi-cycle commands start with two unlocks
// R5 - high address bits only matter for targets
// R6 - identifier reads at low address 00, 01
// R7 - identifier bytes carry odd parity
// R8 - protect read at 0,1,0 gives bit0
// R9 - identifier mode ends only on reset
// R10 - device powers up in read mode
// R11 - program: unlocks, A0H, target with byte
// R12 - address falls late, data rises early
// R13 - program starts at final strobe rise
// R14 - completion shows written bit 7
// R15 - poll the same address being programmed
// R16 - commands ignored while programming
// R17 - programming only clears bits
// R18 - programs in any address order
// R19 - chip erase six cycles exactly
// R20 - sector erase sixth cycle 30H at sector
// R21 - suspend and resume are single writes
// R22 - suspended: touch only non-erasing sectors
`timescale 1ns/100ps
`include "fcd_regs.svh"
module fcd_host
   import fcd_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic req_valid,
   input wire fcd_op_type req_op,
   input wire logic [18:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic [7:0] dq_in,
   output logic req_ready,
   output logic resp_valid,
   output logic [7:0] resp_data,
   output logic resp_fail,
   output logic erase_active,
   output logic erase_suspended,
   output logic [18:0] flash_addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   output logic chip_sel_n,
   output logic write_n,
   output logic out_en_n
);
   typedef enum logic [2:0] {
      fcd_idle,
      fcd_issue,
      fcd_wait,
      fcd_poll,
      fcd_poll_wait
   } fcd_state_type;

   fcd_state_type state;
   fcd_op_type op;
   logic [18:0] tgt_addr;
   logic [7:0] tgt_data;
   logic [2:0] step;
   logic [2:0] last_step;
   logic cyc_start;
   logic cyc_write;
   logic [18:0] cyc_addr;
   logic [7:0] cyc_wdata;
   logic [7:0] cyc_rdata;
   logic cyc_done;
   logic [18:0] next_addr;
   logic [7:0] next_data;
   logic next_write;

   // sequence table: each op is a list of writes, optionally a final read
   always_comb begin
      next_addr = `FCD_UNLOCK1_ADDR;
      next_data = `FCD_UNLOCK1_DATA;
      next_write = 1'b1;
      // R4 unlock pair first
      if (step == 3'd1 || step == 3'd4) begin
         next_addr = `FCD_UNLOCK2_ADDR;
         next_data = `FCD_UNLOCK2_DATA;
      end
      unique case (op)
         fcd_op_reset,
         fcd_op_suspend,
         fcd_op_resume: begin
            // R3 R21 single write, any address
            next_addr = tgt_addr;
            next_data = (op == fcd_op_reset) ? `FCD_CMD_RESET :
               (op == fcd_op_suspend) ? `FCD_CMD_SUSPEND : `FCD_CMD_RESUME;
         end
         fcd_op_reset_long: begin
            // R3 F0H third, then a read of array data
            if (step == 3'd2) next_data = `FCD_CMD_RESET;
            // a fourth write here would reopen an unlock
            if (step == 3'd3) begin
               next_addr = tgt_addr;
               next_write = 1'b0;
            end
         end
         fcd_op_ident_read: begin
            // R6 R8 read at requested low address after 90H
            if (step == 3'd2) next_data = `FCD_CMD_IDENT;
            if (step == 3'd3) begin
               next_addr = tgt_addr;
               next_write = 1'b0;
            end
         end
         fcd_op_program: begin
            // R11 A0H then target and byte
            if (step == 3'd2) next_data = `FCD_CMD_PROGRAM;
            if (step == 3'd3) begin
               next_addr = tgt_addr;
               next_data = tgt_data;
            end
         end
         fcd_op_chip_erase,
         fcd_op_sector_erase: begin
            // R19 R20 setup, unlocks again, final code
            if (step == 3'd2) next_data = `FCD_CMD_ERASE_SETUP;
            if (step == 3'd5) begin
               next_addr = (op == fcd_op_chip_erase) ? `FCD_UNLOCK1_ADDR :
                  tgt_addr;
               next_data = (op == fcd_op_chip_erase) ?
                  `FCD_CMD_CHIP_ERASE : `FCD_CMD_SECTOR_ERASE;
            end
         end
      endcase
   end

   always_comb begin
      unique case (op)
         fcd_op_reset,
         fcd_op_suspend,
         fcd_op_resume: last_step = 3'd0;
         fcd_op_chip_erase,
         fcd_op_sector_erase: last_step = 3'd5;
         default: last_step = 3'd3;
      endcase
   end

   assign cyc_start = (state == fcd_issue) || (state == fcd_poll);
   assign cyc_write = (state == fcd_poll) ? 1'b0 : next_write;
   // R15 poll at the programmed address
   assign cyc_addr = (state == fcd_poll) ? tgt_addr : next_addr;
   assign cyc_wdata = next_data;

   fcd_bus_cycle u_cycle (
      .mclk(mclk),
      .reset(reset),
      .start(cyc_start),
      .is_write(cyc_write),
      .addr(cyc_addr),
      .wdata(cyc_wdata),
      .dq_in(dq_in),
      .flash_addr(flash_addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .chip_sel_n(chip_sel_n),
      .write_n(write_n),
      .out_en_n(out_en_n),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );

   // sequencer; one request at a time keeps the device order intact
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= fcd_idle;
         op <= fcd_op_reset;
         tgt_addr <= 19'h00000;
         tgt_data <= 8'h00;
         step <= 3'd0;
         req_ready <= 1'b1;
         resp_valid <= 1'b0;
         resp_data <= 8'h00;
         resp_fail <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         unique case (state)
            fcd_idle: begin
               if (req_valid && req_ready) begin
                  op <= req_op;
                  tgt_addr <= req_addr;
                  tgt_data <= req_data;
                  step <= 3'd0;
                  req_ready <= 1'b0;
                  state <= fcd_issue;
               end
            end
            fcd_issue: state <= fcd_wait;
            fcd_wait: begin
               if (cyc_done) begin
                  if (step != last_step) begin
                     step <= step + 3'd1;
                     state <= fcd_issue;
                  end else if (op == fcd_op_program) begin
                     // R13 device already running; R16 send nothing but polls
                     state <= fcd_poll;
                  end else begin
                     resp_data <= cyc_rdata;
                     resp_fail <= 1'b0;
                     resp_valid <= 1'b1;
                     req_ready <= 1'b1;
                     state <= fcd_idle;
                  end
               end
            end
            fcd_poll: state <= fcd_poll_wait;
            fcd_poll_wait: begin
               if (cyc_done) begin
                  // R14 finished when bit 7 matches the byte
                  if (cyc_rdata[`FCD_POLL_BIT] == tgt_data[`FCD_POLL_BIT]) begin
                     resp_data <= cyc_rdata;
                     // R17 a 0 asked back to 1 shows as a mismatch
                     resp_fail <= (cyc_rdata != tgt_data);
                     resp_valid <= 1'b1;
                     req_ready <= 1'b1;
                     state <= fcd_idle;
                  end else if (cyc_rdata[`FCD_LIMIT_BIT]) begin
                     resp_data <= cyc_rdata;
                     resp_fail <= 1'b1;
                     resp_valid <= 1'b1;
                     req_ready <= 1'b1;
                     state <= fcd_idle;
                  end else begin
                     state <= fcd_poll;
                  end
               end
            end
         endcase
      end
   end

   // erase tracking; completion is not polled here, software resets it
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         erase_active <= 1'b0;
         erase_suspended <= 1'b0;
      end else if (state == fcd_wait && cyc_done && step == last_step) begin
         unique case (op)
            fcd_op_sector_erase: erase_active <= 1'b1;
            fcd_op_chip_erase: erase_active <= 1'b1;
            // R2 suspend only sets while erase_active, which a sector or a chip erase sets
            fcd_op_suspend: erase_suspended <= erase_active;
            fcd_op_resume: erase_suspended <= 1'b0;
            fcd_op_reset,
            fcd_op_reset_long: begin
               erase_active <= 1'b0;
               erase_suspended <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   AST_PROGRAM_POLLS_TARGET: assert property (@(posedge mclk)
      disable iff (reset)
      state == fcd_poll |=> flash_addr == tgt_addr) // R15
      else $error("poll read not at programmed address");
   AST_UNLOCK_FIRST: assert property (@(posedge mclk) disable iff (reset)
      (state == fcd_issue && step == 3'd0 && last_step != 3'd0) |=>
      flash_addr == `FCD_UNLOCK1_ADDR && dq_out == `FCD_UNLOCK1_DATA) // R4
      else $error("sequence does not open with first unlock");
   AST_NO_WRITE_WHILE_POLL: assert property (@(posedge mclk)
      disable iff (reset)
      state == fcd_poll_wait |-> write_n) // R16
      else $error("write issued during program");
   AST_ONE_REQUEST: assert property (@(posedge mclk) disable iff (reset)
      resp_valid |-> req_ready && state == fcd_idle)
      else $error("response without returning ready");
   AST_SUSPEND_GATED: assert property (@(posedge mclk) disable iff (reset)
      $rose(erase_suspended) |-> $past(erase_active)) // R2
      else $error("suspend recorded without erase");
endmodule

// [verif/fcd_flash_model.sv]
// behavioural model of the byte-wide flash device on the host's pins
`timescale 1ns/100ps
module fcd_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h07, // arbitrary, odd parity
   parameter logic [7:0] PART_ID = 8'h8c, // arbitrary, odd parity
   parameter logic [7:0] PROTECT = 8'h24
) (
   input wire logic [18:0] addr,
   input wire logic [7:0] din,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   output logic [7:0] dout
);
   logic [7:0] mem [int];
   logic [18:0] la;
   logic [18:0] pa;
   logic [7:0] pd;
   logic [7:0] rd = 8'h00;
   logic [2:0] esec;
   logic fail;
   logic susp = 1'b0;
   int step = 0;
   int mode = 0; // 0 read, 1 ident, 2 programming, 3 erasing
   int polls;
   int wr_count = 0;
   wire wr_low = !chip_sel_n && !write_n;

   function automatic logic [7:0] peek(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction

   always @(posedge wr_low) la = addr;

   always @(negedge wr_low) begin
      wr_count++;
      if (mode == 2) begin
      end else if (mode == 3 && din == 8'hb0) begin
         susp = 1'b1;
      end else if (mode == 3 && susp && din == 8'h30) begin
         susp = 1'b0;
      end else if (mode == 3 && !susp) begin
         mode = 0;
         step = 0;
      end else if (step == 0 && din == 8'hf0) begin
         mode = 0;
         susp = 1'b0;
      end else begin
         // low address decode, bad cycle restarts
         case (step)
            0, 4: step = (la[14:0] == 15'h5555 && din == 8'haa) ? step + 1 : 0;
            1, 5: step = (la[14:0] == 15'h2aaa && din == 8'h55) ? step + 1 : 0;
            2: begin
               if (la[14:0] != 15'h5555) step = 0;
               else if (din == 8'hf0) begin
                  mode = 0;
                  susp = 1'b0;
                  step = 0;
               end
               else if (din == 8'h90) begin
                  mode = 1;
                  step = 0;
               end
               else if (din == 8'ha0) step = 3;
               else if (din == 8'h80 && !susp) step = 4;
               else step = 0;
            end
            3: begin
               step = 0;
               if (!(susp && la[18:16] == esec)) begin
                  pa = la;
                  pd = din;
                  fail = (peek(la) & din) != din;
                  mem[la] = peek(la) & din;
                  mode = 2;
                  polls = 2;
               end
            end
            6: begin
               step = 0;
               if (la[14:0] == 15'h5555 && din == 8'h10) mem.delete();
               else if (din == 8'h30) begin
                  esec = la[18:16];
                  for (int k = 0; k < 65536; k++)
                     if (mem.exists({esec, k[15:0]}))
                        mem.delete({esec, k[15:0]});
                  mode = 3;
               end
            end
            default: step = 0;
         endcase
      end
   end

   // either strobe may fall last; act once both are low
   always @(negedge out_en_n or negedge chip_sel_n) begin
      if (!chip_sel_n && !out_en_n) begin
         if (mode == 2) begin
            polls--;
            if (addr != pa) rd = 8'h00;
            else if (fail) rd = {~pd[7], 2'b01, 5'h00};
            else if (polls == 0) rd = peek(pa);
            else rd = {~pd[7], 7'h00};
            if (fail || polls == 0) mode = susp ? 3 : 0;
         end else if (mode == 1) begin
            if (addr[7:0] == 8'h00) rd = MAKER_ID;
            else if (addr[7:0] == 8'h01) rd = PART_ID;
            else if (!addr[6] && addr[1:0] == 2'b10)
               rd = {7'h00, PROTECT[addr[18:16]]};
            else rd = 8'h00;
         end else if (mode == 3 && !susp) rd = 8'h00;
         else rd = peek(addr);
      end
   end

   // released bus shows no stale value
   assign dout = (!chip_sel_n && !out_en_n) ? rd : ~rd;
endmodule

// [verif/test_fcd_host.sv]
// self-checking bench for the flash command host
`timescale 1ns/100ps
module test_fcd_host;
   import fcd_pkg::*;
   localparam logic [7:0] MAKER = 8'h07;
   localparam logic [7:0] PART = 8'h8c;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   fcd_op_type req_op = fcd_op_reset;
   logic [18:0] req_addr = 19'h00000;
   logic [7:0] req_data = 8'h00;
   logic [7:0] dq_in, flash_q, resp_data, dq_out;
   logic req_ready, resp_valid, resp_fail, erase_active, erase_suspended;
   logic [18:0] flash_addr;
   logic dq_oe, chip_sel_n, write_n, out_en_n;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int c0;

   assign dq_in = dq_oe ? dq_out : flash_q;
   always #50 mclk = ~mclk;

   fcd_host u_dut (.mclk(mclk), .reset(reset), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .dq_in(dq_in), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_fail(resp_fail),
      .erase_active(erase_active), .erase_suspended(erase_suspended),
      .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
      .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n));

   fcd_flash_model
      u_flash (.addr(flash_addr), .din(dq_out), .chip_sel_n(chip_sel_n),
      .write_n(write_n), .out_en_n(out_en_n), .dout(flash_q));

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // generous ceiling, the tests need about 450 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic run_op(input fcd_op_type op, input logic [18:0] a,
                         input logic [7:0] d);
      int n;
      n = 0;
      c0 = u_flash.wr_count;
      @(posedge mclk);
      #1;
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_data = d;
      while (req_ready !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 400) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 400) check(32'h0, 32'h1);
   endtask

   task automatic t_ident();
      run_op(fcd_op_ident_read, 19'h70000, 8'h00);
      check(resp_data, MAKER);
      check(^resp_data, 1'b1);
      run_op(fcd_op_ident_read, 19'h00001, 8'h00);
      check(resp_data, PART);
      check(^resp_data, 1'b1);
      run_op(fcd_op_ident_read, 19'h28002, 8'h00);
      check(resp_data[0], 1'b1);
      run_op(fcd_op_ident_read, 19'h38002, 8'h00);
      check(resp_data[0], 1'b0);
      check(u_flash.mode, 1);
      run_op(fcd_op_reset, 19'h00000, 8'h00);
      check(u_flash.mode, 0);
      $display("ident test done");
   endtask

   task automatic t_program();
      run_op(fcd_op_program, 19'h12345, 8'h5a);
      check(u_flash.wr_count - c0, 4);
      check(resp_fail, 1'b0);
      check(resp_data, 8'h5a);
      check(u_flash.mode, 0);
      run_op(fcd_op_program, 19'h00010, 8'h33);
      check(u_flash.peek(19'h00010), 8'h33);
      run_op(fcd_op_program, 19'h12345, 8'ha5);
      check(resp_fail, 1'b1);
      check(u_flash.peek(19'h12345), 8'h00);
      $display("program test done");
   endtask

   task automatic t_erase();
      run_op(fcd_op_program, 19'h20000, 8'h11);
      run_op(fcd_op_sector_erase, 19'h21234, 8'h00);
      check(u_flash.wr_count - c0, 6);
      check(u_flash.peek(19'h20000), 8'hff);
      check(u_flash.peek(19'h12345), 8'h00);
      check(erase_active, 1'b1);
      run_op(fcd_op_suspend, 19'h45678, 8'h00);
      check(u_flash.wr_count - c0, 1);
      check(erase_suspended, 1'b1);
      run_op(fcd_op_program, 19'h00020, 8'h42);
      check(u_flash.peek(19'h00020), 8'h42);
      run_op(fcd_op_resume, 19'h00000, 8'h00);
      check(erase_suspended, 1'b0);
      run_op(fcd_op_reset, 19'h00000, 8'h00);
      check(erase_active, 1'b0);
      run_op(fcd_op_suspend, 19'h00000, 8'h00);
      check(erase_suspended, 1'b0);
      run_op(fcd_op_reset_long, 19'h00000, 8'h00);
      check(u_flash.mode, 0);
      check(u_flash.wr_count - c0, 3);
      check(resp_data, 8'hff);
      run_op(fcd_op_chip_erase, 19'h00000, 8'h00);
      check(u_flash.wr_count - c0, 6);
      check(u_flash.peek(19'h00010), 8'hff);
      run_op(fcd_op_reset, 19'h00000, 8'h00);
      $display("erase test done");
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      #1;
      reset = 1'b0;
      check(u_flash.mode, 0);
      t_ident();
      t_program();
      t_erase();
      test_done();
   end
endmodule
